// ==== design/complex_add_sub_16_32.sv ====
// complex add-with-load and subtract datapath with its vector register file
`timescale 1ns/1ns
`include "complex_add_sub_16_32_params.svh"

// Contract
// - First operand is one register: 16-bit real half and 16-bit imaginary half.
// - Second operand: 32-bit signed real and imaginary registers.
// - First operand halves sign-extended to 32 bits, shifted left.
// - Add: 32-bit sum of shifted half and second operand part.
// - Subtract: 32-bit difference, shifted half minus second operand part.
// - Result shifted right; round when enabled, else truncate.
// - Saturate to signed 16 bits when enabled, else keep low 16 bits.
// - Add-with-load writes packed result into the add result register.
// - Subtract writes packed result into the subtract result register.
// - Add-with-load sets real overflow flag on real-part overflow.
// - Add-with-load sets imaginary overflow flag on imaginary-part overflow.
// - Subtract sets real and imaginary overflow flags likewise.
// - Add-with-load also loads one memory word into the load destination, unless it is register 5, 8 or unmapped.
// - Add-with-load recognised by low word and zero top nibble; rest of high word holds destination, pointer.
// - Subtract recognised by its fixed single low word.
// - Add and parallel load complete in one cycle.
// - Subtract completes in one cycle; results visible to next instruction.
module complex_add_sub_16_32
    import complex_add_sub_16_32_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic issue_valid_i,
    input wire logic [31:0] instr_word_i,
    input wire logic [31:0] mem_word_i,
    input wire settings_type settings_i,
    input wire logic flag_clear_i,
    input wire reg_write_type reg_write_i,
    input wire logic [3:0] read_index_i,
    output logic [31:0] read_data_o,
    output logic [31:0] add_result_o,
    output logic [31:0] sub_result_o,
    output logic [31:0] vector_status_o,
    output logic real_overflow_flag_o,
    output logic imag_overflow_flag_o,
    output logic op_done_o,
    output logic illegal_op_o,
    output logic load_dropped_o
);

    typedef struct packed {
        logic [`CAS_VREG_COUNT-1:0][31:0] vreg;
        logic [31:0] read_data;
        logic [31:0] vector_status_reg;
        logic done;
        logic illegal;
        logic load_dropped;
    } state_type;

    state_type state_reg;
    state_type state_next;

    op_type op;
    logic [31:0] src_a_packed;
    logic [15:0] src_a_high_half;
    logic [15:0] src_a_low_half;
    logic [15:0] a_real_half;
    logic [15:0] a_imag_half;
    logic [31:0] src_b_real;
    logic [31:0] src_b_imag;
    logic [15:0] real_result;
    logic [15:0] imag_result;
    logic real_overflow;
    logic imag_overflow;
    logic [31:0] packed_result;
    logic [3:0] load_dest_reg;
    logic [7:0] mem_operand_ptr;
    logic real_flag;
    logic imag_flag;

    function automatic op_type decode_op(input logic [31:0] word);
        logic [15:0] low_word;
        low_word = word[`CAS_LSW_MSB:0];
        // low word plus zero top nibble
        if ((low_word == `CAS_ADD_LOAD_LSW) &&
            (word[`CAS_MSW_ZERO_MSB:`CAS_MSW_ZERO_LSB] == 4'h0)) begin
            decode_op = OP_ADD_LOAD;
        end else if (low_word == `CAS_SUB_LSW) begin
            decode_op = OP_SUB;
        end else begin
            decode_op = OP_NONE;
        end
    endfunction : decode_op

    function automatic logic index_exists(input logic [3:0] index);
        index_exists = (index <= `CAS_VREG_LAST);
    endfunction : index_exists

    function automatic logic [31:0] pack_halves(
        input logic order,
        input logic [15:0] real_part,
        input logic [15:0] imag_part
    );
        if (order) begin
            pack_halves = {imag_part, real_part};
        end else begin
            pack_halves = {real_part, imag_part};
        end
    endfunction : pack_halves

    assign op = issue_valid_i ? decode_op(instr_word_i) : OP_NONE;

    assign src_a_packed = state_reg.vreg[`CAS_IDX_SRC_A];
    assign src_a_high_half = src_a_packed[31:16];
    assign src_a_low_half = src_a_packed[15:0];

    assign a_real_half = settings_i.complex_pack_order ? src_a_low_half : src_a_high_half;
    assign a_imag_half = settings_i.complex_pack_order ? src_a_high_half : src_a_low_half;

    assign src_b_real = state_reg.vreg[`CAS_IDX_SRC_B_REAL];
    assign src_b_imag = state_reg.vreg[`CAS_IDX_SRC_B_IMAG];

    assign load_dest_reg = instr_word_i[`CAS_DEST_MSB:`CAS_DEST_LSB];
    assign mem_operand_ptr = instr_word_i[`CAS_MEM_PTR_MSB:`CAS_MEM_PTR_LSB];

    cplx_part_calc real_calc (
        .half_i(a_real_half),
        .other_i(src_b_real),
        .subtract_i(op == OP_SUB),
        .settings_i(settings_i),
        .result_o(real_result),
        .overflow_o(real_overflow)
    );

    cplx_part_calc imag_calc (
        .half_i(a_imag_half),
        .other_i(src_b_imag),
        .subtract_i(op == OP_SUB),
        .settings_i(settings_i),
        .result_o(imag_result),
        .overflow_o(imag_overflow)
    );

    assign packed_result = pack_halves(settings_i.complex_pack_order, real_result, imag_result);

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.illegal = 1'b0;
        state_next.load_dropped = 1'b0;
        real_flag = state_reg.vector_status_reg[`CAS_STATUS_REAL_OVF_BIT];
        imag_flag = state_reg.vector_status_reg[`CAS_STATUS_IMAG_OVF_BIT];

        // clear first so a same-cycle overflow still leaves the flag set
        if (flag_clear_i) begin
            real_flag = 1'b0;
            imag_flag = 1'b0;
        end

        case (op)
            OP_ADD_LOAD: begin
                // result, flags and load in one edge
                state_next.done = 1'b1;
                state_next.vreg[`CAS_IDX_ADD_RESULT] = packed_result;
                real_flag = real_flag | real_overflow;
                imag_flag = imag_flag | imag_overflow;
                if (!index_exists(load_dest_reg) ||
                    (load_dest_reg == `CAS_IDX_ADD_RESULT) ||
                    (load_dest_reg == `CAS_IDX_VREG_EIGHT)) begin
                    state_next.load_dropped = 1'b1;
                end else begin
                    state_next.vreg[load_dest_reg] = mem_word_i;
                end
            end
            OP_SUB: begin
                state_next.done = 1'b1;
                state_next.vreg[`CAS_IDX_SUB_RESULT] = packed_result;
                real_flag = real_flag | real_overflow;
                imag_flag = imag_flag | imag_overflow;
            end
            OP_NONE: begin
                state_next.illegal = issue_valid_i;
                // host writes only land in cycles with no instruction retiring
                if (reg_write_i.enable && index_exists(reg_write_i.index)) begin
                    state_next.vreg[reg_write_i.index] = reg_write_i.data;
                end
            end
            default: begin
                state_next.illegal = issue_valid_i;
            end
        endcase

        state_next.vector_status_reg = `CAS_WORD_RESET;
        state_next.vector_status_reg[`CAS_STATUS_REAL_OVF_BIT] = real_flag;
        state_next.vector_status_reg[`CAS_STATUS_IMAG_OVF_BIT] = imag_flag;
        state_next.vector_status_reg[`CAS_STATUS_PACK_BIT] = settings_i.complex_pack_order;
        state_next.vector_status_reg[`CAS_STATUS_RND_BIT] = settings_i.round_enable;
        state_next.vector_status_reg[`CAS_STATUS_SAT_BIT] = settings_i.saturate_enable;
        state_next.vector_status_reg[`CAS_STATUS_SHL_MSB:`CAS_STATUS_SHL_LSB] =
            settings_i.left_shift_amount;
        state_next.vector_status_reg[`CAS_STATUS_SHR_MSB:`CAS_STATUS_SHR_LSB] =
            settings_i.right_shift_amount;

        // read shows the file before this edge; unmapped indexes read zero
        if (index_exists(read_index_i)) begin
            state_next.read_data = state_reg.vreg[read_index_i];
        end else begin
            state_next.read_data = `CAS_WORD_RESET;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign read_data_o = state_reg.read_data;
    assign add_result_o = state_reg.vreg[`CAS_IDX_ADD_RESULT];
    assign sub_result_o = state_reg.vreg[`CAS_IDX_SUB_RESULT];
    assign vector_status_o = state_reg.vector_status_reg;
    assign real_overflow_flag_o = state_reg.vector_status_reg[`CAS_STATUS_REAL_OVF_BIT];
    assign imag_overflow_flag_o = state_reg.vector_status_reg[`CAS_STATUS_IMAG_OVF_BIT];
    assign op_done_o = state_reg.done;
    assign illegal_op_o = state_reg.illegal;
    assign load_dropped_o = state_reg.load_dropped;

endmodule : complex_add_sub_16_32

// ==== design/complex_add_sub_16_32_params.svh ====
// constants for the complex add and subtract datapath
`ifndef COMPLEX_ADD_SUB_16_32_PARAMS_SVH
`define COMPLEX_ADD_SUB_16_32_PARAMS_SVH

`define CAS_ADD_LOAD_LSW 16'he3fa
`define CAS_SUB_LSW 16'he505
`define CAS_LSW_MSB 15
`define CAS_MSW_ZERO_MSB 31
`define CAS_MSW_ZERO_LSB 28
`define CAS_DEST_MSB 27
`define CAS_DEST_LSB 24
`define CAS_MEM_PTR_MSB 23
`define CAS_MEM_PTR_LSB 16

`define CAS_VREG_COUNT 9
`define CAS_VREG_LAST 4'h8
`define CAS_IDX_SRC_B_IMAG 4'h2
`define CAS_IDX_SRC_B_REAL 4'h3
`define CAS_IDX_SRC_A 4'h4
`define CAS_IDX_ADD_RESULT 4'h5
`define CAS_IDX_SUB_RESULT 4'h6
`define CAS_IDX_VREG_EIGHT 4'h8

`define CAS_WORD_RESET 32'h0000_0000
`define CAS_SAT_MAX 16'h7fff
`define CAS_SAT_MIN 16'h8000
`define CAS_RANGE_MAX 33'sh0_0000_7fff
`define CAS_RANGE_MIN 33'sh1_ffff_8000

`define CAS_STATUS_REAL_OVF_BIT 0
`define CAS_STATUS_IMAG_OVF_BIT 1
`define CAS_STATUS_PACK_BIT 2
`define CAS_STATUS_RND_BIT 3
`define CAS_STATUS_SAT_BIT 4
`define CAS_STATUS_SHL_LSB 8
`define CAS_STATUS_SHL_MSB 12
`define CAS_STATUS_SHR_LSB 16
`define CAS_STATUS_SHR_MSB 20

`endif

// ==== design/complex_add_sub_16_32_pkg.sv ====
// types shared by the complex add and subtract datapath
package complex_add_sub_16_32_pkg;

    typedef struct packed {
        logic complex_pack_order;
        logic [4:0] left_shift_amount;
        logic [4:0] right_shift_amount;
        logic round_enable;
        logic saturate_enable;
    } settings_type;

    typedef struct packed {
        logic enable;
        logic [3:0] index;
        logic [31:0] data;
    } reg_write_type;

    typedef enum logic [2:0] {
        OP_NONE = 3'b001,
        OP_ADD_LOAD = 3'b010,
        OP_SUB = 3'b100
    } op_type;

endpackage : complex_add_sub_16_32_pkg

// ==== design/cplx_part_calc.sv ====
// one part (real or imaginary) of the complex 16 plus or minus 32 datapath
`timescale 1ns/1ns
`include "complex_add_sub_16_32_params.svh"

module cplx_part_calc
    import complex_add_sub_16_32_pkg::*;
(
    input wire logic [15:0] half_i,
    input wire logic [31:0] other_i,
    input wire logic subtract_i,
    input wire settings_type settings_i,
    output logic [15:0] result_o,
    output logic overflow_o
);

    logic [31:0] extended;
    logic [31:0] shifted;
    logic [31:0] combined;
    logic signed [32:0] widened;
    logic signed [32:0] scaled;
    logic [4:0] round_pos;

    always_comb begin
        round_pos = settings_i.right_shift_amount - 5'd1;
        extended = {{16{half_i[15]}}, half_i};
        shifted = extended << settings_i.left_shift_amount;
        if (subtract_i) begin
            combined = shifted - other_i;
        end else begin
            combined = shifted + other_i;
        end
        // one spare bit so the rounding increment cannot wrap
        widened = $signed({combined[31], combined});
        if (settings_i.round_enable && (settings_i.right_shift_amount != 5'd0)) begin
            widened = widened + (33'sd1 <<< round_pos);
        end
        scaled = widened >>> settings_i.right_shift_amount;
        overflow_o = (scaled > `CAS_RANGE_MAX) || (scaled < `CAS_RANGE_MIN);
        if (settings_i.saturate_enable && overflow_o) begin
            result_o = scaled[32] ? `CAS_SAT_MIN : `CAS_SAT_MAX;
        end else begin
            result_o = scaled[15:0];
        end
    end

endmodule : cplx_part_calc

// ==== test/cas_mem_model.sv ====
// memory side of the issuing pipeline: returns the word at a pointer
`timescale 1ns/1ns

module cas_mem_model (
    input wire logic [7:0] ptr_i,
    output logic [31:0] word_o
);
    // word depends on every pointer bit
    assign word_o = {ptr_i ^ 8'h5a, ~ptr_i, ptr_i, 8'hc3};
endmodule : cas_mem_model

// ==== test/complex_add_sub_16_32_assertions.sv ====
// port-level checks for the complex add and subtract datapath
`timescale 1ns/1ns

module complex_add_sub_16_32_assertions
    import complex_add_sub_16_32_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic issue_valid_i,
    input wire logic [31:0] instr_word_i,
    input wire logic [31:0] mem_word_i,
    input wire settings_type settings_i,
    input wire logic flag_clear_i,
    input wire reg_write_type reg_write_i,
    input wire logic [3:0] read_index_i,
    input wire logic [31:0] read_data_o,
    input wire logic [31:0] add_result_o,
    input wire logic [31:0] sub_result_o,
    input wire logic [31:0] vector_status_o,
    input wire logic real_overflow_flag_o,
    input wire logic imag_overflow_flag_o,
    input wire logic op_done_o,
    input wire logic illegal_op_o,
    input wire logic load_dropped_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire add_ok = issue_valid_i && instr_word_i[15:0] == 16'he3fa && instr_word_i[31:28] == 4'h0;
    wire sub_ok = issue_valid_i && instr_word_i[15:0] == 16'he505;
    wire any_ok = add_ok || sub_ok;
    wire bad_dst = instr_word_i[27:24] == 4'h5 || instr_word_i[27:24] >= 4'h8;
    wire wr6 = reg_write_i.enable && reg_write_i.index == 4'h6;
    op_retire_a: assert property (any_ok |=> op_done_o)
        else $error("retire pulse missing");
    no_retire_a: assert property (!any_ok |=> !op_done_o)
        else $error("retire pulse without instruction");
    illegal_word_a: assert property (issue_valid_i && !any_ok |=> illegal_op_o)
        else $error("unknown word not flagged");
    // an add-load aimed at register 6 also moves the subtract result
    wire ld6 = add_ok && instr_word_i[27:24] == 4'h6;
    sub_hold_a: assert property (!sub_ok && !ld6 && !(wr6 && !add_ok) |=> $stable(sub_result_o))
        else $error("subtract result changed without cause");
    load_drop_a: assert property (add_ok |=> load_dropped_o == $past(bad_dst))
        else $error("load drop pulse wrong");
    flag_sticky_a: assert property (real_overflow_flag_o && !flag_clear_i |=> real_overflow_flag_o)
        else $error("real flag lost");
    flag_clear_a: assert property (flag_clear_i && !issue_valid_i
        |=> !real_overflow_flag_o && !imag_overflow_flag_o)
        else $error("flags not cleared");
    status_mirror_a: assert property (vector_status_o[1:0] == {imag_overflow_flag_o, real_overflow_flag_o})
        else $error("status flag bits differ from flags");
    add_cov: cover property (add_ok && !bad_dst);
    sub_cov: cover property (sub_ok ##1 sub_ok);
    drop_cov: cover property (load_dropped_o);
endmodule : complex_add_sub_16_32_assertions

bind complex_add_sub_16_32 complex_add_sub_16_32_assertions i_complex_add_sub_16_32_assertions (.*);

// ==== test/complex_add_sub_16_32_tb.sv ====
// self-checking bench for the complex add and subtract datapath
`timescale 1ns/1ns

module complex_add_sub_16_32_tb;
    import complex_add_sub_16_32_pkg::*;
    logic sys_clk_i = 1'b0, reset_n_i = 1'b0, issue_valid_i = 1'b0, flag_clear_i = 1'b0;
    logic [31:0] instr_word_i = 32'h0, mem_word_i, read_data_o, add_result_o, sub_result_o;
    logic [31:0] vector_status_o;
    logic [3:0] read_index_i = 4'h0;
    settings_type settings_i = '0;
    reg_write_type reg_write_i = '0;
    logic real_overflow_flag_o, imag_overflow_flag_o, op_done_o, illegal_op_o, load_dropped_o;
    int miscompares = 0, checks = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    cas_mem_model i_cas_mem_model (.ptr_i(instr_word_i[23:16]), .word_o(mem_word_i));
    complex_add_sub_16_32 i_complex_add_sub_16_32 (.*);
    task stop_test;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task step; @(posedge sys_clk_i); #1; endtask : step
    // requests change only once per time step, so no task lowers its own strobe
    task wr(input logic [3:0] i, input logic [31:0] d);
        issue_valid_i = 1'b0; reg_write_i = '{1'b1, i, d}; step();
    endtask : wr
    task rd(input logic [3:0] i, input logic [31:0] e);
        issue_valid_i = 1'b0; reg_write_i.enable = 1'b0; read_index_i = i; step(); chk(read_data_o, e);
    endtask : rd
    task issue(input logic [31:0] w);
        reg_write_i.enable = 1'b0; issue_valid_i = 1'b1; instr_word_i = w; step();
    endtask : issue
    function automatic logic [16:0] ref_part(logic [15:0] h, logic [31:0] o, logic s, settings_type c);
        logic [31:0] t;
        logic signed [32:0] v;
        logic ovf;
        t = {{16{h[15]}}, h} << c.left_shift_amount;
        t = s ? t - o : t + o;
        v = $signed({t[31], t});
        if (c.round_enable && c.right_shift_amount != 5'd0) v = v + (33'sd1 <<< (c.right_shift_amount - 5'd1));
        v = v >>> c.right_shift_amount;
        ovf = v > 33'sd32767 || v < -33'sd32768;
        return {ovf, (ovf && c.saturate_enable) ? (v[32] ? 16'h8000 : 16'h7fff) : v[15:0]};
    endfunction : ref_part
    task run(input logic s, input settings_type c, input logic [31:0] a, br, bi, input logic [3:0] d);
        logic [16:0] re, im;
        logic [7:0] p;
        p = {4'h9, d};
        re = ref_part(c.complex_pack_order ? a[15:0] : a[31:16], br, s, c);
        im = ref_part(c.complex_pack_order ? a[31:16] : a[15:0], bi, s, c);
        flag_clear_i = 1'b1;
        wr(4'h4, a);
        flag_clear_i = 1'b0;
        wr(4'h3, br);
        wr(4'h2, bi);
        settings_i = c;
        issue(s ? 32'h0000e505 : {4'h0, d, p, 16'he3fa});
        chk(op_done_o, 32'h1);
        chk(s ? sub_result_o : add_result_o, c.complex_pack_order ? {im[15:0], re[15:0]} : {re[15:0], im[15:0]});
        chk({real_overflow_flag_o, imag_overflow_flag_o}, {re[16], im[16]});
        chk(vector_status_o[20:2], {c.right_shift_amount, 3'b000, c.left_shift_amount, 3'b000,
            c.saturate_enable, c.round_enable, c.complex_pack_order});
        if (!s) rd(d, {p ^ 8'h5a, ~p, p, 8'hc3});
    endtask : run
    initial begin
        #(4 * 3000);
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        #1 reset_n_i = 1'b1;
        chk(vector_status_o, 32'h0);
        run(1'b0, '{1'b0, 5'd0, 5'd0, 1'b0, 1'b0}, 32'h00040003, 32'hd, 32'hc, 4'h7);
        chk(add_result_o, 32'h0011000f);
        run(1'b0, '{1'b0, 5'd2, 5'd1, 1'b1, 1'b0}, 32'hfffc0003, 32'hd, 32'hfffffff7, 4'h1);
        chk(add_result_o, 32'hffff0002);
        run(1'b1, '{1'b1, 5'd0, 5'd1, 1'b0, 1'b0}, 32'h00060004, 32'hd, 32'h16, 4'h0);
        chk(sub_result_o, 32'hfff8fffb);
        run(1'b1, '{1'b0, 5'd0, 5'd0, 1'b0, 1'b1}, 32'h7fff8000, 32'hffff0000, 32'h1, 4'h0);
        chk(sub_result_o, 32'h7fff8000);
        chk({real_overflow_flag_o, imag_overflow_flag_o}, 32'h3);
        run(1'b0, '{1'b0, 5'd4, 5'd0, 1'b0, 1'b0}, 32'h7fff8001, 32'h0, 32'h0, 4'h3);
        run(1'b1, '{1'b1, 5'd31, 5'd31, 1'b1, 1'b1}, 32'h8000ffff, 32'h7fffffff, 32'h80000000, 4'h0);
        $display("arithmetic cases done");
        for (int k = 0; k < 2; k++) begin
            issue({4'h0, k ? 4'h8 : 4'h5, 8'h11, 16'he3fa});
            chk(load_dropped_o, 32'h1);
        end
        rd(4'h8, 32'h0);
        // near miss words are not executed
        for (int k = 0; k < 2; k++) begin
            issue(k ? 32'h0000e504 : 32'h1000e3fa);
            chk({illegal_op_o, op_done_o}, 32'h2);
        end
        $display("refusal cases done");
        settings_i = '0;
        wr(4'h3, 32'h0);
        wr(4'h2, 32'h0);
        // subtract right behind the load sees the loaded word
        issue(32'h0494e3fa);
        issue(32'h0000e505);
        chk(sub_result_o, 32'hce6b94c3);
        $display("back to back case done");
        stop_test();
    end
endmodule : complex_add_sub_16_32_tb
